// ===== design/cms_pkg.sv
`default_nettype none
package cms_pkg;

    // register numbering
    localparam logic [3:0] CMS_REG_SP = 4'hd;
    localparam logic [3:0] CMS_REG_LR = 4'he;
    localparam logic [3:0] CMS_REG_PC = 4'hf;
    localparam int CMS_NUM_GPR = 13;

    // reset vector addresses
    localparam logic [31:0] CMS_VEC_SP_ADDR = 32'h0000_0000;
    localparam logic [31:0] CMS_VEC_PC_ADDR = 32'h0000_0004;
    localparam logic [31:0] CMS_WORD_BYTES = 32'h0000_0004;

    // status field positions
    localparam int CMS_FLAG_N = 31;
    localparam int CMS_FLAG_V = 28;
    localparam int CMS_TBIT = 24;
    localparam int CMS_EXC_HI = 5;
    localparam int CMS_CTRL_SPSEL = 1;
    localparam int CMS_PRIORITY_MASK_BIT = 0;

    // exception numbers
    localparam logic [5:0] CMS_EXC_THREAD = 6'h00;
    localparam logic [5:0] CMS_EXC_NMI = 6'h02;
    localparam logic [5:0] CMS_EXC_HARD = 6'h03;
    localparam logic [5:0] CMS_EXC_SVC = 6'h0b;
    localparam logic [5:0] CMS_EXC_PENDABLE_SERVICE_EXCEPTION = 6'h0e;
    localparam logic [5:0] CMS_EXC_TICK = 6'h0f;
    localparam logic [5:0] CMS_EXC_IRQ_LO = 6'h10;
    localparam logic [5:0] CMS_EXC_IRQ_HI = 6'h2f;

    // special register selectors
    typedef enum logic [3:0] {
        CMS_SR_FLAGS,      // condition_flags
        CMS_SR_EXC,        // current_exception_number
        CMS_SR_EXEC,       // execution_state
        CMS_SR_FLAGS_EXC,  // flags_and_exception_view
        CMS_SR_FLAGS_EXEC, // flags_and_exec_view
        CMS_SR_EXC_EXEC,   // exception_and_exec_view
        CMS_SR_ALL,        // combined_status_word
        CMS_SR_MSP,
        CMS_SR_PSP,
        CMS_SR_PRIORITY_MASK,
        CMS_SR_CONTROL
    } cms_sreg_t;

    // state bit load cause
    typedef enum logic [1:0] {
        CMS_TSRC_BRANCH,   // branch_via_reg, branch_link_via_reg, pop
        CMS_TSRC_EXC_RET,  // stacked status restore
        CMS_TSRC_VECTOR    // vector fetch at exception entry
    } cms_tsrc_t;

    // general register write request
    typedef struct packed {
        logic        en;
        logic [3:0]  idx;
        logic [31:0] data;
    } cms_reg_wr_t;

    // special register move request
    typedef struct packed {
        logic        wr;
        cms_sreg_t   sel;
        logic [31:0] data;
    } cms_sreg_req_t;

    // exception entry / return event
    typedef struct packed {
        logic        entry;
        logic        ret;
        logic [5:0]  num;
        logic [31:0] stacked_psr;
        logic        last;   // no further pending or active exceptions
    } cms_exc_ev_t;

endpackage
`default_nettype wire

// ===== design/cms_reg_bank.sv
`timescale 1ns/1ps
`default_nettype none
module cms_reg_bank
    import cms_pkg::*;
#(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic               i_clock,
    input  wire logic               i_rst,
    // write port
    input  wire logic               i_we,
    input  wire logic [3:0]         i_widx,
    input  wire logic [WIDTH-1:0]   i_wdata,
    // read port
    input  wire logic [3:0]         i_ridx,
    output logic      [WIDTH-1:0]   o_rdata
);

    logic [WIDTH-1:0] gpr_r [CMS_NUM_GPR];

    // general data registers
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < CMS_NUM_GPR; i++) begin
                gpr_r[i] <= '0;
            end
        end else if (i_we && (i_widx < CMS_REG_SP)) begin
            gpr_r[i_widx] <= i_wdata;
        end
    end

    // out of range index reads zero
    always_comb begin
        if (i_ridx < CMS_REG_SP) begin
            o_rdata = gpr_r[i_ridx];
        end else begin
            o_rdata = '0;
        end
    end

endmodule
`default_nettype wire

// ===== design/cms_restart_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module cms_restart_ctl
    import cms_pkg::*;
(
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // multi-transfer instruction progress
    input  wire logic        i_multi_start,
    input  wire logic [31:0] i_multi_pc,
    input  wire logic        i_multi_done,
    input  wire logic        i_irq_take,
    input  wire logic        i_exc_ret_last,
    // abandon / restart outputs
    output logic             o_abandon,
    output logic             o_restart,
    output logic [31:0]      o_restart_pc
);

    logic        busy_r;
    logic        pend_r;
    logic [31:0] pc_r;

    // combinational: stop the transfer now
    assign o_abandon = busy_r & i_irq_take;

    // track an in-flight multi_load / multi_store
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            busy_r <= 1'b0;
            pc_r   <= '0;
        end else if (i_multi_start) begin
            busy_r <= 1'b1;
            pc_r   <= i_multi_pc;
        end else if (i_multi_done || o_abandon) begin
            busy_r <= 1'b0;
        end
    end

    // remember abandonment until servicing completes
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pend_r <= 1'b0;
        end else if (o_abandon) begin
            pend_r <= 1'b1;
        end else if (i_exc_ret_last) begin
            pend_r <= 1'b0;
        end
    end

    // restart from first transfer at the saved address
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_restart    <= 1'b0;
            o_restart_pc <= '0;
        end else begin
            o_restart    <= pend_r & i_exc_ret_last;
            o_restart_pc <= pc_r;
        end
    end

endmodule
`default_nettype wire

// ===== design/cms_core_state.sv
// Behaviour
// - reset exits to application mode
// - application only after all exceptions
// - push decrements then writes
// - two pointers; handler uses main
// - control bit 1 picks thread pointer
// - reset loads main pointer from 0
// - reset loads counter from 4
// - 13 pointer, 14 link, 15 counter
// - flags in bits 31..28
// - bits 5:0 hold exception number
// - state bit at bit 24
// - execution bits read zero
// - exception-number writes ignored
// - status fields single, paired, whole
// - state bit follows loaded bit 0, bit 24 on exception return
// - clear state bit faults execution
// - interrupt abandons multi-transfer
// - abandoned multi-transfer restarts fully
// - handler reads select zero, ignores writes
// - mask blocks configurable exceptions
`timescale 1ns/1ps
`default_nettype none
module cms_core_state
    import cms_pkg::*;
(
    // clock and reset
    input  wire logic          i_clock,
    input  wire logic          i_rst,
    // reset vector fetch
    output logic               o_vec_req,
    output logic [31:0]        o_vec_addr,
    input  wire logic          i_vec_ack,
    input  wire logic [31:0]   i_vec_data,
    // core register access
    input  wire cms_reg_wr_t   i_reg_wr,
    input  wire logic [3:0]    i_reg_ridx,
    output logic [31:0]        o_reg_rdata,
    // condition flag update from execution
    input  wire logic          i_flags_we,
    input  wire logic [3:0]    i_flags_nzcv,
    // special register moves
    input  wire cms_sreg_req_t i_sreg,
    output logic [31:0]        o_sreg_rdata,
    // stack push / pop
    input  wire logic          i_push,
    input  wire logic          i_pop,
    output logic [31:0]        o_push_addr,
    // state-bit load
    input  wire logic          i_tload,
    input  wire cms_tsrc_t     i_tload_src,
    input  wire logic [31:0]   i_tload_val,
    // exceptions
    input  wire cms_exc_ev_t   i_exc,
    input  wire logic          i_exec_attempt,
    input  wire logic          i_exc_cfg_prio,
    output logic               o_exc_blocked,
    output logic               o_hard_fault,
    // multi-transfer instructions
    input  wire logic          i_multi_start,
    input  wire logic [31:0]   i_multi_pc,
    input  wire logic          i_multi_done,
    input  wire logic          i_irq_take,
    output logic               o_multi_abandon,
    output logic               o_multi_restart,
    output logic [31:0]        o_multi_restart_pc,
    // state view
    output logic               o_handler_mode,
    output logic               o_running,
    output logic [31:0]        o_active_stack_pointer,
    output logic [31:0]        o_program_counter,
    output logic [31:0]        o_combined_status_word
);

    typedef enum logic [1:0] {
        CMS_ST_FETCH_SP,
        CMS_ST_FETCH_PC,
        CMS_ST_RUN
    } cms_state_t;

    cms_state_t  state_r;
    logic        handler_r;
    logic [31:0] main_stack_pointer_r;
    logic [31:0] process_stack_pointer_r;
    logic [31:0] return_link_r;
    logic [31:0] program_counter_r;
    logic [3:0]  flags_r;
    logic [5:0]  exc_num_r;
    logic        tbit_r;
    logic        priority_mask_r;
    logic        spsel_r;
    logic [31:0] gpr_rdata;
    logic        use_psp;
    logic [31:0] sp_nxt;
    logic        sreg_wr;
    logic        sp_wr;

    // status word assembly from the three fields
    function automatic logic [31:0] psr_view(input logic f, input logic e,
                                             input logic x);
        logic [31:0] v;
        v = '0;
        if (f) begin
            v[CMS_FLAG_N:CMS_FLAG_V] = flags_r;
        end
        if (e) begin
            v[CMS_EXC_HI:0] = exc_num_r;
        end
        if (x) begin
            v[CMS_TBIT] = tbit_r;
        end
        return v;
    endfunction

    // does a special register selector include the flags field
    function automatic logic has_flags(input cms_sreg_t s);
        return (s == CMS_SR_FLAGS) || (s == CMS_SR_FLAGS_EXC) ||
               (s == CMS_SR_FLAGS_EXEC) || (s == CMS_SR_ALL);
    endfunction

    cms_reg_bank #(
        .WIDTH (32)
    ) u_bank (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_we    (i_reg_wr.en),
        .i_widx  (i_reg_wr.idx),
        .i_wdata (i_reg_wr.data),
        .i_ridx  (i_reg_ridx),
        .o_rdata (gpr_rdata)
    );

    cms_restart_ctl u_restart (
        .i_clock        (i_clock),
        .i_rst          (i_rst),
        .i_multi_start  (i_multi_start),
        .i_multi_pc     (i_multi_pc),
        .i_multi_done   (i_multi_done),
        .i_irq_take     (i_irq_take),
        .i_exc_ret_last (i_exc.ret & i_exc.last),
        .o_abandon      (o_multi_abandon),
        .o_restart      (o_multi_restart),
        .o_restart_pc   (o_multi_restart_pc)
    );

    // handler always main, thread by select bit
    assign use_psp = ~handler_r & spsel_r;
    assign o_active_stack_pointer = use_psp ? process_stack_pointer_r
                                            : main_stack_pointer_r;
    // full-descending: decrement first, write at new address
    assign sp_nxt = o_active_stack_pointer - CMS_WORD_BYTES;
    assign o_push_addr = sp_nxt;

    assign sreg_wr = i_sreg.wr && (state_r == CMS_ST_RUN);
    assign sp_wr = i_reg_wr.en && (i_reg_wr.idx == CMS_REG_SP);

    // reset vector sequencing
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_r <= CMS_ST_FETCH_SP;
        end else begin
            unique case (state_r)
                CMS_ST_FETCH_SP: begin
                    if (i_vec_ack) begin
                        state_r <= CMS_ST_FETCH_PC;
                    end
                end
                CMS_ST_FETCH_PC: begin
                    if (i_vec_ack) begin
                        state_r <= CMS_ST_RUN;
                    end
                end
                CMS_ST_RUN: begin
                    state_r <= CMS_ST_RUN;
                end
            endcase
        end
    end

    assign o_vec_req = (state_r != CMS_ST_RUN);
    assign o_vec_addr = (state_r == CMS_ST_FETCH_SP) ? CMS_VEC_SP_ADDR
                                                      : CMS_VEC_PC_ADDR;
    assign o_running = (state_r == CMS_ST_RUN);

    // processor mode
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            handler_r <= 1'b0;
        end else if (i_exc.entry) begin
            handler_r <= 1'b1;
        end else if (i_exc.ret && i_exc.last) begin
            handler_r <= 1'b0;
        end
    end

    // main stack pointer
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            main_stack_pointer_r <= '0;
        end else if (state_r == CMS_ST_FETCH_SP && i_vec_ack) begin
            main_stack_pointer_r <= i_vec_data;
        end else if (sreg_wr && i_sreg.sel == CMS_SR_MSP) begin
            main_stack_pointer_r <= i_sreg.data;
        end else if (sp_wr && !use_psp) begin
            main_stack_pointer_r <= i_reg_wr.data;
        end else if (i_push && !use_psp) begin
            main_stack_pointer_r <= sp_nxt;
        end else if (i_pop && !use_psp) begin
            main_stack_pointer_r <= main_stack_pointer_r + CMS_WORD_BYTES;
        end
    end

    // process stack pointer
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            process_stack_pointer_r <= '0;
        end else if (sreg_wr && i_sreg.sel == CMS_SR_PSP) begin
            process_stack_pointer_r <= i_sreg.data;
        end else if (sp_wr && use_psp) begin
            process_stack_pointer_r <= i_reg_wr.data;
        end else if (i_push && use_psp) begin
            process_stack_pointer_r <= sp_nxt;
        end else if (i_pop && use_psp) begin
            process_stack_pointer_r <= process_stack_pointer_r + CMS_WORD_BYTES;
        end
    end

    // link register
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            return_link_r <= '0;
        end else if (i_reg_wr.en && i_reg_wr.idx == CMS_REG_LR) begin
            return_link_r <= i_reg_wr.data;
        end
    end

    // program counter
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            program_counter_r <= '0;
        end else if (state_r == CMS_ST_FETCH_PC && i_vec_ack) begin
            program_counter_r <= {i_vec_data[31:1], 1'b0};
        end else if (i_tload) begin
            program_counter_r <= {i_tload_val[31:1], 1'b0};
        end else if (i_reg_wr.en && i_reg_wr.idx == CMS_REG_PC) begin
            program_counter_r <= i_reg_wr.data;
        end
    end

    // flags; execution beats a move
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            flags_r <= '0;
        end else if (i_flags_we) begin
            flags_r <= i_flags_nzcv;
        end else if (i_exc.ret) begin
            flags_r <= i_exc.stacked_psr[CMS_FLAG_N:CMS_FLAG_V];
        end else if (sreg_wr && has_flags(i_sreg.sel)) begin
            flags_r <= i_sreg.data[CMS_FLAG_N:CMS_FLAG_V];
        end
    end

    // exception number: never written by moves
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            exc_num_r <= CMS_EXC_THREAD;
        end else if (i_exc.entry) begin
            exc_num_r <= i_exc.num;
        end else if (i_exc.ret) begin
            exc_num_r <= i_exc.stacked_psr[CMS_EXC_HI:0];
        end
    end

    // state bit, hardware loads only
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            tbit_r <= 1'b0;
        end else if (state_r == CMS_ST_FETCH_PC && i_vec_ack) begin
            tbit_r <= i_vec_data[0];
        end else if (i_tload) begin
            unique case (i_tload_src)
                CMS_TSRC_EXC_RET: tbit_r <= i_tload_val[CMS_TBIT];
                default:          tbit_r <= i_tload_val[0];
            endcase
        end
    end

    // priority mask
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            priority_mask_r <= 1'b0;
        end else if (sreg_wr && i_sreg.sel == CMS_SR_PRIORITY_MASK) begin
            priority_mask_r <= i_sreg.data[CMS_PRIORITY_MASK_BIT];
        end
    end

    // stack-select bit; writes ignored in handler mode
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            spsel_r <= 1'b0;
        end else if (sreg_wr && i_sreg.sel == CMS_SR_CONTROL
                     && !handler_r) begin
            spsel_r <= i_sreg.data[CMS_CTRL_SPSEL];
        end
    end

    // only nmi and hard fault have fixed priority
    assign o_exc_blocked = priority_mask_r & i_exc_cfg_prio;

    // executing with state bit clear faults instead
    assign o_hard_fault = o_running & i_exec_attempt & ~tbit_r;

    // special register read
    always_comb begin
        o_sreg_rdata = '0;
        unique case (i_sreg.sel)
            CMS_SR_FLAGS:      o_sreg_rdata = psr_view(1'b1, 1'b0, 1'b0);
            CMS_SR_EXC:        o_sreg_rdata = psr_view(1'b0, 1'b1, 1'b0);
            CMS_SR_EXEC:       o_sreg_rdata = '0;
            CMS_SR_FLAGS_EXC:  o_sreg_rdata = psr_view(1'b1, 1'b1, 1'b0);
            CMS_SR_FLAGS_EXEC: o_sreg_rdata = psr_view(1'b1, 1'b0, 1'b0);
            CMS_SR_EXC_EXEC:   o_sreg_rdata = psr_view(1'b0, 1'b1, 1'b0);
            CMS_SR_ALL:        o_sreg_rdata = psr_view(1'b1, 1'b1, 1'b0);
            CMS_SR_MSP:        o_sreg_rdata = main_stack_pointer_r;
            CMS_SR_PSP:        o_sreg_rdata = process_stack_pointer_r;
            CMS_SR_PRIORITY_MASK:    o_sreg_rdata[CMS_PRIORITY_MASK_BIT] = priority_mask_r;
            CMS_SR_CONTROL:    o_sreg_rdata[CMS_CTRL_SPSEL] = use_psp;
            default:           o_sreg_rdata = '0;
        endcase
    end

    // core register read by number
    always_comb begin
        unique case (i_reg_ridx)
            CMS_REG_SP: o_reg_rdata = o_active_stack_pointer;
            CMS_REG_LR: o_reg_rdata = return_link_r;
            CMS_REG_PC: o_reg_rdata = program_counter_r;
            default:    o_reg_rdata = gpr_rdata;
        endcase
    end

    assign o_handler_mode = handler_r;
    assign o_program_counter = program_counter_r;
    assign o_combined_status_word = psr_view(1'b1, 1'b1, 1'b1);

endmodule
`default_nettype wire

// ===== verification/cms_core_state_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module cms_core_state_monitor
    import cms_pkg::*;
(
    // clock and reset
    input wire logic          i_clock,
    input wire logic          i_rst,
    // vector fetch
    input wire logic          o_vec_req,
    input wire logic [31:0]   o_vec_addr,
    input wire logic          i_vec_ack,
    input wire logic [31:0]   i_vec_data,
    // register traffic
    input wire cms_reg_wr_t   i_reg_wr,
    input wire cms_sreg_req_t i_sreg,
    input wire logic [31:0]   o_sreg_rdata,
    input wire logic          i_push,
    input wire logic          i_pop,
    input wire logic [31:0]   o_push_addr,
    input wire logic          i_tload,
    input wire cms_tsrc_t     i_tload_src,
    input wire logic [31:0]   i_tload_val,
    // exceptions and restart
    input wire cms_exc_ev_t   i_exc,
    input wire logic          i_exec_attempt,
    input wire logic          i_exc_cfg_prio,
    input wire logic          o_exc_blocked,
    input wire logic          o_hard_fault,
    input wire logic          i_irq_take,
    input wire logic          o_multi_abandon,
    input wire logic          o_multi_restart,
    // state view
    input wire logic          o_handler_mode,
    input wire logic          o_running,
    input wire logic [31:0]   o_active_stack_pointer,
    input wire logic [31:0]   o_combined_status_word
);
    default clocking mcb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    // no competing pointer update in this cycle
    wire logic quiet = !i_pop && !i_reg_wr.en && !i_sreg.wr && !i_exc.entry
                       && !i_exc.ret;

    AST_THREAD_START: assert property (o_vec_req |->
        !o_handler_mode && !o_running) else $error("not thread at start");
    AST_VEC_ORDER: assert property (
        o_vec_req && i_vec_ack && o_vec_addr == CMS_VEC_SP_ADDR
        |=> o_vec_req && o_vec_addr == CMS_VEC_PC_ADDR)
        else $error("vector fetch order");
    AST_SP_LOAD: assert property (
        o_vec_req && i_vec_ack && o_vec_addr == CMS_VEC_SP_ADDR
        |=> o_active_stack_pointer == $past(i_vec_data))
        else $error("main pointer not loaded");
    AST_PUSH: assert property (i_push && quiet |=>
        o_active_stack_pointer == $past(o_push_addr))
        else $error("push pointer wrong");
    AST_HANDLER_MSP: assert property (
        o_handler_mode && i_sreg.sel == CMS_SR_MSP
        |-> o_active_stack_pointer == o_sreg_rdata)
        else $error("handler not on main pointer");
    AST_CTRL_HANDLER: assert property (
        o_handler_mode && i_sreg.sel == CMS_SR_CONTROL |-> !o_sreg_rdata[1])
        else $error("select bit set in handler");
    AST_RETURN: assert property (i_exc.ret && !i_exc.entry |=>
        o_handler_mode == !$past(i_exc.last)) else $error("return mode");
    AST_ENTRY: assert property (i_exc.entry |=>
        o_handler_mode && o_combined_status_word[5:0] == $past(i_exc.num))
        else $error("entry number");
    AST_EXEC_ZERO: assert property (i_sreg.sel == CMS_SR_EXEC |->
        o_sreg_rdata == 32'h0) else $error("exec view not zero");
    AST_STATE_FAULT: assert property (
        $past(i_tload && i_tload_src == CMS_TSRC_BRANCH) && o_running
        && i_exec_attempt |-> o_hard_fault == !$past(i_tload_val[0]))
        else $error("state bit fault");
    AST_MASK: assert property (
        i_sreg.wr && i_sreg.sel == CMS_SR_PRIORITY_MASK && o_running
        |=> o_exc_blocked == ($past(i_sreg.data[0]) && i_exc_cfg_prio))
        else $error("mask blocking");
    AST_ABANDON: assert property (o_multi_abandon |->
        i_irq_take) else $error("abandon without interrupt");
    AST_RESTART: assert property (o_multi_restart |->
        $past(i_exc.ret && i_exc.last)) else $error("restart untimed");
endmodule

bind cms_core_state cms_core_state_monitor mon_u (.*);
`default_nettype wire

// ===== verification/test_cms_core_state.sv
`timescale 1ns/1ps
`default_nettype none
module test_cms_core_state
    import cms_pkg::*;
;
    logic          i_clock, i_rst, o_vec_req, i_vec_ack, i_push, i_pop;
    logic          i_flags_we, i_tload, i_exec_attempt, i_exc_cfg_prio;
    logic          o_exc_blocked, o_hard_fault, i_multi_start, i_multi_done;
    logic          i_irq_take, o_multi_abandon, o_multi_restart;
    logic          o_handler_mode, o_running;
    logic [31:0]   o_vec_addr, i_vec_data, o_reg_rdata, o_sreg_rdata;
    logic [31:0]   o_push_addr, i_tload_val, i_multi_pc, o_multi_restart_pc;
    logic [31:0]   o_active_stack_pointer, o_program_counter;
    logic [31:0]   o_combined_status_word;
    logic [3:0]    i_reg_ridx, i_flags_nzcv;
    cms_reg_wr_t   i_reg_wr;
    cms_sreg_req_t i_sreg;
    cms_tsrc_t     i_tload_src;
    cms_exc_ev_t   i_exc;
    int            bad_count, samples_checked;

    cms_core_state dut_u (.*);

    // 40 MHz clock
    always #12.5 i_clock = ~i_clock;

    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // take pulses at this edge, drop them, settle
    task automatic fin;
        @(posedge i_clock);
        {i_vec_ack, i_push, i_pop, i_flags_we, i_tload, i_irq_take} <= 6'h00;
        {i_multi_start, i_multi_done, i_reg_wr.en, i_sreg.wr} <= 4'h0;
        {i_exc.entry, i_exc.ret} <= 2'h0;
        @(negedge i_clock);
    endtask

    task automatic sreg(input cms_sreg_t s, logic w, logic [31:0] d);
        @(posedge i_clock);
        i_sreg <= '{wr: w, sel: s, data: d};
        fin;
    endtask

    task automatic regw(input logic [3:0] idx, input logic [31:0] d);
        @(posedge i_clock);
        i_reg_wr <= '{en: 1'b1, idx: idx, data: d};
        i_reg_ridx <= idx;
        fin;
    endtask

    task automatic exc(input logic en, rt, logic [5:0] n, logic [31:0] combined_status_word,
                       logic last);
        @(posedge i_clock);
        i_exc <= '{entry: en, ret: rt, num: n, stacked_psr: combined_status_word, last: last};
        fin;
    endtask

    task automatic tld(input cms_tsrc_t src, input logic [31:0] v);
        @(posedge i_clock);
        {i_tload, i_tload_src, i_tload_val} <= {1'b1, src, v};
        fin;
    endtask

    // watchdog
    initial begin
        repeat (5000) @(posedge i_clock);
        bad_count++;
        test_done;
    end

    initial begin
        {i_clock, i_vec_ack, i_push, i_pop, i_flags_we, i_tload} = '0;
        {i_exec_attempt, i_exc_cfg_prio, i_multi_start, i_multi_done} = '0;
        {i_irq_take, i_vec_data, i_tload_val, i_multi_pc, i_reg_ridx} = '0;
        {i_flags_nzcv, i_reg_wr, i_sreg, i_exc, bad_count} = '0;
        samples_checked = 0;
        i_rst = 1'b1;
        i_tload_src = CMS_TSRC_BRANCH;
        repeat (6) @(posedge i_clock);
        i_rst <= 1'b0;
        // vector fetch
        @(posedge i_clock);
        {i_vec_ack, i_vec_data} <= {1'b1, 32'h2000_0100};
        @(posedge i_clock);
        i_vec_data <= 32'h0000_0201;
        fin;
        chk(o_running, 1'b1);
        chk(o_handler_mode, 1'b0);
        chk(o_active_stack_pointer, 32'h2000_0100);
        chk(o_program_counter, 32'h0000_0200);
        $display("boot test done");

        regw(4'h3, 32'h1234_5678);
        chk(o_reg_rdata, 32'h1234_5678);
        regw(CMS_REG_LR, 32'hffff_fff9);
        chk(o_reg_rdata, 32'hffff_fff9);
        regw(CMS_REG_PC, 32'h0000_0310);
        chk(o_program_counter, 32'h0000_0310);
        regw(CMS_REG_SP, 32'h2000_0200);
        chk(o_active_stack_pointer, 32'h2000_0200);
        chk(o_push_addr, 32'h2000_01fc);
        @(posedge i_clock);
        i_push <= 1'b1;
        fin;
        chk(o_active_stack_pointer, 32'h2000_01fc);
        @(posedge i_clock);
        i_pop <= 1'b1;
        fin;
        chk(o_active_stack_pointer, 32'h2000_0200);
        $display("register test done");

        sreg(CMS_SR_PSP, 1'b1, 32'h2000_0800);
        sreg(CMS_SR_CONTROL, 1'b1, 32'h0000_0002);
        chk(o_active_stack_pointer, 32'h2000_0800);
        @(posedge i_clock);
        {i_flags_we, i_flags_nzcv} <= 5'h1a;
        fin;
        exc(1'b1, 1'b0, CMS_EXC_SVC, 32'h0, 1'b0);
        chk(o_handler_mode, 1'b1);
        sreg(CMS_SR_MSP, 1'b0, 32'h0);
        chk(o_sreg_rdata, 32'h2000_0200);
        chk(o_active_stack_pointer, 32'h2000_0200);
        sreg(CMS_SR_CONTROL, 1'b1, 32'h0);
        chk(o_sreg_rdata & 32'h2, 32'h0);
        // status views: flags a, number 0b
        for (int s = 0; s <= 6; s++) begin
            sreg(cms_sreg_t'(s), 1'b0, 32'h0);
            chk(o_sreg_rdata, ((s inside {0, 3, 4, 6}) ? 32'ha000_0000 : 0)
                | ((s inside {1, 3, 5, 6}) ? 32'h0b : 0));
        end
        sreg(CMS_SR_ALL, 1'b1, 32'h5100_003f);
        chk(o_sreg_rdata, 32'h5000_000b);
        exc(1'b1, 1'b0, CMS_EXC_TICK, 32'h0, 1'b0);
        exc(1'b0, 1'b1, 6'h0, 32'h0100_000b, 1'b0);
        chk(o_handler_mode, 1'b1);
        chk(o_combined_status_word & 32'h3f, 32'h0b);
        exc(1'b0, 1'b1, 6'h0, 32'h0100_0000, 1'b1);
        chk(o_handler_mode, 1'b0);
        chk(o_active_stack_pointer, 32'h2000_0800);
        $display("mode test done");

        @(posedge i_clock);
        i_exec_attempt <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            tld(CMS_TSRC_BRANCH, 32'h0000_0301);
            chk(o_hard_fault, 1'b0);
            tld(cms_tsrc_t'(k), 32'h0000_0300);
            chk(o_hard_fault, 1'b1);
        end
        chk(o_program_counter, 32'h0000_0300);
        tld(CMS_TSRC_BRANCH, 32'h0000_0301);
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clock);
            i_exc_cfg_prio <= k[0];
            sreg(CMS_SR_PRIORITY_MASK, 1'b1, {31'h0, k[1]});
            chk(o_exc_blocked, k[0] & k[1]);
        end
        $display("state and mask test done");

        @(posedge i_clock);
        {i_multi_start, i_multi_pc} <= {1'b1, 32'h0000_0400};
        fin;
        @(posedge i_clock);
        i_irq_take <= 1'b1;
        @(negedge i_clock);
        chk(o_multi_abandon, 1'b1);
        fin;
        exc(1'b1, 1'b0, CMS_EXC_IRQ_LO, 32'h0, 1'b0);
        exc(1'b0, 1'b1, 6'h0, 32'h0100_0000, 1'b1);
        chk(o_multi_restart, 1'b1);
        chk(o_multi_restart_pc, 32'h0000_0400);
        $display("restart test done");
        test_done;
    end
endmodule
`default_nettype wire
